// File: verif/fsc_arr_model.sv
// Behavioural flash array answering erase and verify phases
`timescale 1ns/10ps
module fsc_arr_model (
  // Clock
  input wire logic clk,
  // Phase requests from the sequencer
  input wire logic erase_req,
  input wire logic verify_req,
  // Bench controls: answer delay and verify faults
  input wire logic [3:0] delay,
  input wire logic [1:0] fault,
  // Answers
  output logic done,
  output logic verify_err,
  output logic verify_uncorr
);
  logic [3:0] cnt_r; // Cycles spent in the current phase
  logic tgl_r = 1'b0; // Filler so stale verify lines never look settled
  ////////////////////////////////////////////////////////////////////////
  // Phase timer restarts at every answer
  always_ff @(posedge clk) begin
    tgl_r <= ~tgl_r;
    cnt_r <= (done || !(erase_req || verify_req)) ? 4'h0 : cnt_r + 4'h1;
  end
  // One cycle answer once the delay has run
  assign done = (erase_req || verify_req) && (cnt_r == delay);
  // Verify results are only valid with the answer
  assign verify_err = (done && verify_req) ? fault[1] : tgl_r;
  assign verify_uncorr = (done && verify_req) ? fault[0] : ~tgl_r;
endmodule

// File: verif/fsc_ctrl_chk.sv
// Port level assertions for the sector erase and security controller
`timescale 1ns/10ps
module fsc_ctrl_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Array side
  input wire logic arr_erase_req,
  input wire logic arr_verify_req,
  input wire logic [fsc_pkg::GA_W-1:0] arr_addr,
  input wire logic arr_done,
  input wire logic pflash0_read_inhibit,
  // Status, power and interrupt
  input wire logic secured,
  input wire logic stop_req,
  input wire logic stop_ack,
  input wire logic cmd_irq
);
  import fsc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic busy; // Any array phase in progress
  assign busy = arr_erase_req || arr_verify_req;
  ////////////////////////////////////////////////////////////////////////
  // Bus answers after exactly one wait cycle
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus wait longer than one cycle");
  // Erase and verify never overlap
  phase_excl_a: assert property (!(arr_erase_req && arr_verify_req))
    else $error("erase and verify together");
  // Verify follows erase at once
  erase_verify_a: assert property (arr_erase_req && arr_done |=> arr_verify_req && !arr_erase_req)
    else $error("verify did not follow erase");
  // Target address holds through erase
  addr_hold_a: assert property (arr_erase_req && $past(arr_erase_req) |-> $stable(arr_addr))
    else $error("array address moved");
  // Only aligned data flash addresses are erased
  erase_addr_a: assert property (arr_erase_req |-> !arr_addr[0] && arr_addr >= DF_BASE
    && arr_addr < DF_BASE + DF_SIZE)
    else $error("erase of illegal address");
  // Stop granted only when idle
  stop_hold_a: assert property (stop_ack |-> stop_req && !busy)
    else $error("stop granted while busy");
  // Command request only when complete
  irq_idle_a: assert property (cmd_irq |-> !busy)
    else $error("command irq while busy");
  // Block zero inhibit is one quiet cycle
  inhibit_one_a: assert property (pflash0_read_inhibit |-> !busy ##1 !pflash0_read_inhibit)
    else $error("read inhibit too long");
  // Security starts secured before the load
  reset_sec_a: assert property (disable iff (1'b0) reset |=> secured)
    else $error("unsecured during reset");
  // Main scenarios reached
  erase_c: cover property (arr_erase_req && arr_done);
  inhibit_c: cover property (pflash0_read_inhibit);
  stop_c: cover property (stop_req && busy ##[1:60] stop_ack);
endmodule
bind fsc_ctrl fsc_ctrl_chk chk_u (.clk, .reset, .avs_read, .avs_write, .avs_waitrequest, .arr_erase_req,
  .arr_verify_req, .arr_addr, .arr_done, .pflash0_read_inhibit, .secured, .stop_req, .stop_ack, .cmd_irq);

// File: verif/tb.sv
// Self-checking bench for the sector erase and security controller
`timescale 1ns/10ps
module tb;
  import fsc_pkg::*;
  logic clk = 0, reset = 1, rd = 0, wr = 0, stp = 0, spc = 0, dd = 0, da = 0, e1 = 0, e2 = 0;
  logic wq, done, verr, vunc, ers_q, ver_q, inh, sec, sack, cirq, eirq;
  logic [7:0] adr = 0, sb = 8'h83; // Secured, keys enabled
  logic [31:0] wd = 0, rdat, rdw;
  logic [22:0] ga;
  logic [3:0] dly = 4'h2;
  logic [1:0] flt = 0;
  logic [15:0] k[4] = '{16'h1357, 16'h2468, 16'h0ACE, 16'h7531};
  int fails = 0, comparisons = 0, cyc = 0, ers = 0, inh_n = 0;
  ////////////////////////////////////////////////////////////////////////
  // Clock and run monitors
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    ers += ers_q;
    inh_n += inh;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  fsc_arr_model am_u (.clk(clk), .erase_req(ers_q), .verify_req(ver_q), .delay(dly), .fault(flt),
    .done(done), .verify_err(verr), .verify_uncorr(vunc));
  fsc_ctrl dut_u (.clk(clk), .reset(reset), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdw), .avs_waitrequest(wq),
    .arr_erase_req(ers_q), .arr_verify_req(ver_q), .arr_addr(), .arr_done(done), .arr_verify_err(verr),
    .arr_verify_uncorr(vunc), .ecc_single_fault(e1), .ecc_double_fault(e2), .pflash0_read_inhibit(inh),
    .sec_byte_in(sb), .stored_key0(k[0]), .stored_key1(k[1]), .stored_key2(k[2]), .stored_key3(k[3]),
    .special_ss_mode(spc), .dbg_erase_verify_done(dd), .dbg_all_erased(da), .secured(sec),
    .stop_req(stp), .stop_ack(sack), .cmd_irq(cirq), .err_irq(eirq));
  ////////////////////////////////////////////////////////////////////////
  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    // Wait states are sampled at each rising edge; data taken at the edge that ends them
    do begin
      @(posedge clk);
    end while (wq);
    rdat = rdw;
    wr <= 0;
    rd <= 0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Load a command, launch it, wait for completion, compare status
  task automatic go(input logic [7:0] c, input logic [22:0] a, input logic [2:0] ix, input logic [47:0] m,
                    input logic [7:0] exp);
    int n;
    bus(1, 0, 0);
    bus(1, 4, {16'h0, c, 1'b0, a[22:16]});
    bus(1, 0, 1);
    bus(1, 4, {16'h0, a[15:0]});
    for (int i = 2; i < 5; i++) begin
      bus(1, 0, i);
      bus(1, 4, {16'h0, m[16*(i-2)+:16]});
    end
    bus(1, 0, {29'h0, ix});
    bus(1, 8, 32'h30);
    bus(1, 8, 32'h80);
    if (stp) @(posedge clk) chk(sack, 0);
    n = 0;
    rdat = 0;
    while (!rdat[7] && n < 60) begin
      bus(0, 8, 0);
      n++;
    end
    chk(rdat & 32'hB3, {24'h0, exp});
  endtask
  task automatic rst(input logic [7:0] b);
    @(posedge clk);
    reset <= 1;
    sb <= b;
    repeat (2) @(posedge clk);
    reset <= 0;
    // Let the security load happen before anything is looked at
    repeat (2) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    reset <= 0;
    bus(0, 8'h18, 0);
    chk(rdat[7:0], 8'h83);
    go(CMD_ERASE_DSECTOR, 23'h100000, 1, 0, 8'hA0);
    go(CMD_VERIFY_KEY, 23'(k[0]), 4, {k[3], k[2], k[1]}, 8'h80);
    bus(0, 8'h18, 0);
    chk({rdat[7:0], sec, 22'(ers)}, {8'h82, 1'b0, 22'h0});
    chk(inh_n, 1);
    go(CMD_ERASE_DSECTOR, 23'h100000, 2, 0, 8'hA0);
    foreach (k[i]) begin
      go(CMD_ERASE_DSECTOR, i[1] ? 23'h100101 : 23'h0FFFFE + 23'(i) * 23'h1002, 1, 0, 8'hA0);
    end
    bus(1, 8'h1C, 32'h8);
    go(CMD_ERASE_DSECTOR, 23'h1003FE, 1, 0, 8'h90);
    chk(ers, 0);
    // Erase phases last delay plus one cycles: 1 + 5 + 9 + 13 in all
    for (int f = 0; f < 4; f++) begin
      flt <= f[1:0];
      dly <= 4'(f * 4);
      stp <= f[0];
      go(CMD_ERASE_DSECTOR, 23'h100F00 + 23'(f * 2), 1, 0, {6'h20, f[1:0]});
      chk(sack, stp);
    end
    chk(ers, 28);
    stp <= 0;
    bus(1, 8'h0C, 32'h80);
    @(posedge clk) chk(cirq, 1);
    bus(1, 8'h0C, 0);
    @(posedge clk) chk(cirq, 0);
    bus(1, 8'h10, 32'h2);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) {e2, e1} <= 2'b10 >> i;
      @(posedge clk) {e2, e1} <= 2'b00;
      bus(0, 8'h14, 0);
      chk(rdat[1:0], 2'b10 >> i);
      chk(eirq, !i);
      bus(1, 8'h14, 32'h3);
    end
    // A new security byte must wait for the next reset
    sb <= 8'h03;
    repeat (2) @(posedge clk);
    chk(sec, 0);
    rst(8'h03);
    chk(sec, 1);
    go(CMD_VERIFY_KEY, 23'(k[0]), 4, {k[3], k[2], k[1]}, 8'hA0);
    chk(sec, 1);
    spc <= 1;
    da <= 1;
    @(posedge clk) dd <= 1;
    @(posedge clk) dd <= 0;
    bus(0, 8'h18, 0);
    chk(sec, 0);
    chk(rdat[7:0], 8'h02);
    spc <= 0;
    k[3] <= 16'hFFFF;
    rst(8'h83);
    // All-ones key runs the check but never matches, and locks the command
    go(CMD_VERIFY_KEY, 23'(k[0]), 4, {16'hFFFF, k[2], k[1]}, 8'h80);
    k[3] <= 16'h7531;
    go(CMD_VERIFY_KEY, 23'(k[0]), 4, {16'h7531, k[2], k[1]}, 8'hA0);
    chk(sec, 1);
    end_of_test();
  end
endmodule

// File: verilog/fsc_ctrl.sv
// Flash data sector erase sequencer with security, key unlock and interrupt requests
`timescale 1ns/10ps
module fsc_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM register slave
  input wire logic [fsc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [fsc_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [fsc_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Flash array sequencing
  output logic arr_erase_req,
  output logic arr_verify_req,
  output logic [fsc_pkg::GA_W-1:0] arr_addr,
  input wire logic arr_done,
  input wire logic arr_verify_err,
  input wire logic arr_verify_uncorr,
  // Flash array read side
  input wire logic ecc_single_fault,
  input wire logic ecc_double_fault,
  output logic pflash0_read_inhibit,
  // Security content of the configuration field
  input wire logic [7:0] sec_byte_in,
  input wire logic [15:0] stored_key0,
  input wire logic [15:0] stored_key1,
  input wire logic [15:0] stored_key2,
  input wire logic [15:0] stored_key3,
  // Operating mode and debug port
  input wire logic special_ss_mode,
  input wire logic dbg_erase_verify_done,
  input wire logic dbg_all_erased,
  output logic secured,
  // Power modes
  input wire logic stop_req,
  output logic stop_ack,
  // Interrupt requests
  output logic cmd_irq,
  output logic err_irq
);
  import fsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic ack_r;                              // Bus answer phase
  logic wr_fire;                            // Write takes effect
  logic [DATA_W-1:0] wmask;                 // Byte lane mask
  logic [DATA_W-1:0] wdata;                 // Masked write data
  logic [DATA_W-1:0] rd_mux;                // Read data select
  logic [DATA_W-1:0] readdata_r;            // Registered read data
  logic [WORD_W-1:0] cmd_obj_r [NUM_OBJ];   // Command object words
  logic [IDX_W-1:0] param_index_r;          // Current parameter index
  logic cmd_complete_flag_r;                // Idle and ready
  logic access_error_flag_r;
  logic protection_violation_flag_r;
  logic verify_status_hi_r;
  logic verify_status_lo_r;
  logic cmd_complete_irq_en_r;
  logic double_fault_irq_en_r;
  logic single_fault_irq_en_r;
  logic double_fault_flag_r;
  logic single_fault_flag_r;
  logic [7:0] security_reg_r;               // Security state
  logic [15:0] dflash_protect_r;            // One bit per sector
  logic loaded_r;                           // Reset load finished
  logic key_locked_r;                       // Key command barred
  logic [GA_W-1:0] arr_addr_r;
  fsc_state_t state_r;
  fsc_state_t state_nxt;
  logic launch;                             // Command launch strobe
  logic set_acc;
  logic set_pv;
  logic set_vs_hi;
  logic set_vs_lo;
  logic done_evt;
  logic key_unsec;
  logic key_lock;
  logic key_match;
  logic [GA_W-1:0] glob_addr;               // Address from word 0 and 1
  logic [GA_W-1:0] df_off;                  // Offset within data flash
  logic [7:0] cmd_code;
  logic addr_valid;
  logic sect_prot;
  logic cmd_avail;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer in the second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_fire = avs_write & ack_r;
  assign avs_readdata = readdata_r;

  // Answer phase toggles once per request
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // Byte enables gate the write lanes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
    wdata = avs_writedata & wmask;
  end

  // Read data select; unmapped offsets read zero
  always_comb begin
    rd_mux = '0;
    case (avs_address)
      OFF_PARAM_INDEX: begin
        rd_mux[IDX_W-1:0] = param_index_r;
      end
      OFF_COMMAND_OBJECT: begin
        if (param_index_r < IDX_W'(NUM_OBJ)) begin
          rd_mux[WORD_W-1:0] = cmd_obj_r[param_index_r];
        end
      end
      OFF_FLASH_STATUS: begin
        rd_mux[BIT_CCF] = cmd_complete_flag_r;
        rd_mux[BIT_ACC] = access_error_flag_r;
        rd_mux[BIT_PV] = protection_violation_flag_r;
        rd_mux[BIT_VS_HI] = verify_status_hi_r;
        rd_mux[BIT_VS_LO] = verify_status_lo_r;
      end
      OFF_FLASH_CONFIG: begin
        rd_mux[BIT_CMD_COMPLETE_IRQ_EN] = cmd_complete_irq_en_r;
      end
      OFF_FLASH_ERROR_CONFIG: begin
        rd_mux[BIT_DFD] = double_fault_irq_en_r;
        rd_mux[BIT_SFD] = single_fault_irq_en_r;
      end
      OFF_FLASH_ERROR_STATUS: begin
        rd_mux[BIT_DFD] = double_fault_flag_r;
        rd_mux[BIT_SFD] = single_fault_flag_r;
      end
      OFF_SECURITY: begin
        rd_mux[7:0] = security_reg_r;
      end
      OFF_DFLASH_PROTECT: begin
        rd_mux[15:0] = dflash_protect_r;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data captured for the answer cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      readdata_r <= '0;
    end else if (avs_read & ~ack_r) begin
      readdata_r <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command object and index; ignored while a command is busy
  always_ff @(posedge clk) begin
    if (reset) begin
      param_index_r <= '0;
    end else if (wr_fire && cmd_complete_flag_r && avs_address == OFF_PARAM_INDEX) begin
      param_index_r <= wdata[IDX_W-1:0];
    end
  end

  // Parameter words written through the index
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_OBJ; i++) begin
        cmd_obj_r[i] <= '0;
      end
    end else if (wr_fire && cmd_complete_flag_r && avs_address == OFF_COMMAND_OBJECT &&
                 param_index_r < IDX_W'(NUM_OBJ)) begin
      cmd_obj_r[param_index_r] <= wdata[WORD_W-1:0];
    end
  end

  // Writing one to the complete flag launches the command
  assign launch = wr_fire && avs_address == OFF_FLASH_STATUS && wdata[BIT_CCF] &&
                  cmd_complete_flag_r && state_r == ST_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  assign cmd_code = cmd_obj_r[0][CODE_LSB +: 8];
  assign glob_addr = {cmd_obj_r[0][GA_HI_W-1:0], cmd_obj_r[1]};
  assign df_off = glob_addr - DF_BASE;
  assign addr_valid = (glob_addr >= DF_BASE) && (df_off < DF_SIZE);
  assign sect_prot = dflash_protect_r[df_off[DF_SECT_LSB +: DF_SECT_W]];

  // Erase needs unsecured or special mode; key check needs normal mode
  always_comb begin
    if (cmd_code == CMD_ERASE_DSECTOR) begin
      cmd_avail = ~secured | special_ss_mode;
    end else begin
      cmd_avail = ~special_ss_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Key comparator on words 1 to 4
  fsc_key_cmp u_key_cmp (
    .key_in0 (cmd_obj_r[1]),
    .key_in1 (cmd_obj_r[2]),
    .key_in2 (cmd_obj_r[3]),
    .key_in3 (cmd_obj_r[4]),
    .key_st0 (stored_key0),
    .key_st1 (stored_key1),
    .key_st2 (stored_key2),
    .key_st3 (stored_key3),
    .match (key_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state and event strobes
  always_comb begin
    state_nxt = state_r;
    set_acc = 1'b0;
    set_pv = 1'b0;
    set_vs_hi = 1'b0;
    set_vs_lo = 1'b0;
    done_evt = 1'b0;
    key_unsec = 1'b0;
    key_lock = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (launch) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (cmd_code == CMD_ERASE_DSECTOR) begin
          if (param_index_r != IDX_ERASE || !cmd_avail || !addr_valid || glob_addr[0]) begin
            set_acc = 1'b1;
            state_nxt = ST_DONE;
          end else if (sect_prot) begin
            set_pv = 1'b1;
            state_nxt = ST_DONE;
          end else begin
            state_nxt = ST_ERASE;
          end
        end else if (cmd_code == CMD_VERIFY_KEY) begin
          if (param_index_r != IDX_KEY || !cmd_avail || key_locked_r ||
              security_reg_r[KEY_ENABLE_FIELD_LSB +: 2] != KEY_ENABLE_FIELD_ENABLED) begin
            set_acc = 1'b1;
            state_nxt = ST_DONE;
          end else begin
            state_nxt = ST_KEYCHK;
          end
        end else begin
          // Commands not handled here are refused
          set_acc = 1'b1;
          state_nxt = ST_DONE;
        end
      end
      ST_ERASE: begin
        if (arr_done) begin
          state_nxt = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        if (arr_done) begin
          set_vs_hi = arr_verify_err;
          set_vs_lo = arr_verify_uncorr;
          state_nxt = ST_DONE;
        end
      end
      ST_KEYCHK: begin
        // Only the security bits or the key lock move; keys and protection are untouched
        if (key_match) begin
          key_unsec = 1'b1;
        end else begin
          key_lock = 1'b1;
        end
        state_nxt = ST_DONE;
      end
      ST_DONE: begin
        done_evt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Array address latched in the check state, whether or not the checks pass
  always_ff @(posedge clk) begin
    if (reset) begin
      arr_addr_r <= '0;
    end else if (state_r == ST_CHECK) begin
      arr_addr_r <= glob_addr;
    end
  end

  assign arr_addr = arr_addr_r;
  assign arr_erase_req = (state_r == ST_ERASE);
  assign arr_verify_req = (state_r == ST_VERIFY);
  assign pflash0_read_inhibit = (state_r == ST_KEYCHK);

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_complete_flag_r <= 1'b0;
    end else if (!loaded_r || done_evt) begin
      cmd_complete_flag_r <= 1'b1;
    end else if (launch) begin
      cmd_complete_flag_r <= 1'b0;
    end
  end

  // Access and protection errors, write one to clear
  always_ff @(posedge clk) begin
    if (reset) begin
      access_error_flag_r <= 1'b0;
      protection_violation_flag_r <= 1'b0;
    end else begin
      access_error_flag_r <= set_acc | (access_error_flag_r &
        ~(wr_fire && avs_address == OFF_FLASH_STATUS && wdata[BIT_ACC]));
      protection_violation_flag_r <= set_pv | (protection_violation_flag_r &
        ~(wr_fire && avs_address == OFF_FLASH_STATUS && wdata[BIT_PV]));
    end
  end

  // Verify status cleared by each launch
  always_ff @(posedge clk) begin
    if (reset) begin
      verify_status_hi_r <= 1'b0;
      verify_status_lo_r <= 1'b0;
    end else begin
      verify_status_hi_r <= set_vs_hi | (verify_status_hi_r & ~launch);
      verify_status_lo_r <= set_vs_lo | (verify_status_lo_r & ~launch);
    end
  end

  // ECC fault flags from array reads, write one to clear
  always_ff @(posedge clk) begin
    if (reset) begin
      double_fault_flag_r <= 1'b0;
      single_fault_flag_r <= 1'b0;
    end else begin
      double_fault_flag_r <= ecc_double_fault | (double_fault_flag_r &
        ~(wr_fire && avs_address == OFF_FLASH_ERROR_STATUS && wdata[BIT_DFD]));
      single_fault_flag_r <= ecc_single_fault | (single_fault_flag_r &
        ~(wr_fire && avs_address == OFF_FLASH_ERROR_STATUS && wdata[BIT_SFD]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_complete_irq_en_r <= 1'b0;
      double_fault_irq_en_r <= 1'b0;
      single_fault_irq_en_r <= 1'b0;
      dflash_protect_r <= '0;
    end else if (wr_fire) begin
      case (avs_address)
        OFF_FLASH_CONFIG: begin
          cmd_complete_irq_en_r <= wdata[BIT_CMD_COMPLETE_IRQ_EN];
        end
        OFF_FLASH_ERROR_CONFIG: begin
          double_fault_irq_en_r <= wdata[BIT_DFD];
          single_fault_irq_en_r <= wdata[BIT_SFD];
        end
        OFF_DFLASH_PROTECT: begin
          dflash_protect_r <= wdata[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Security: loaded once after reset, so later programming waits for reset
  always_ff @(posedge clk) begin
    if (reset) begin
      loaded_r <= 1'b0;
      security_reg_r <= SEC_RESET_VAL;
    end else if (!loaded_r) begin
      loaded_r <= 1'b1;
      security_reg_r <= sec_byte_in;
    end else if (key_unsec) begin
      security_reg_r[SEC_LSB +: 2] <= SEC_UNSECURED;
    end else if (special_ss_mode && dbg_erase_verify_done && dbg_all_erased) begin
      security_reg_r[SEC_LSB +: 2] <= SEC_UNSECURED;
    end
  end

  // Key lock holds until the next reset
  always_ff @(posedge clk) begin
    if (reset) begin
      key_locked_r <= 1'b0;
    end else if (key_lock) begin
      key_locked_r <= 1'b1;
    end
  end

  assign secured = (security_reg_r[SEC_LSB +: 2] != SEC_UNSECURED);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests and power mode handshake
  assign cmd_irq = cmd_complete_flag_r & cmd_complete_irq_en_r;
  assign err_irq = (double_fault_flag_r & double_fault_irq_en_r) |
                   (single_fault_flag_r & single_fault_irq_en_r);
  assign stop_ack = stop_req & cmd_complete_flag_r & (state_r == ST_IDLE);

endmodule

// File: verilog/fsc_key_cmp.sv
// Backdoor key comparator for the flash security controller
`timescale 1ns/10ps
module fsc_key_cmp (
  // Presented keys
  input wire logic [15:0] key_in0,
  input wire logic [15:0] key_in1,
  input wire logic [15:0] key_in2,
  input wire logic [15:0] key_in3,
  // Stored keys
  input wire logic [15:0] key_st0,
  input wire logic [15:0] key_st1,
  input wire logic [15:0] key_st2,
  input wire logic [15:0] key_st3,
  // Result
  output logic match
);
  import fsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // All four must match and every stored key must be a legal value
  always_comb begin
    match = (key_in0 == key_st0) && (key_in1 == key_st1) &&
            (key_in2 == key_st2) && (key_in3 == key_st3) &&
            fsc_key_legal(key_st0) && fsc_key_legal(key_st1) &&
            fsc_key_legal(key_st2) && fsc_key_legal(key_st3);
  end

endmodule

// File: verilog/fsc_pkg.sv
// Shared constants, register map and types for the flash sector erase and security controller
package fsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W = 8;   // Avalon byte address width
  localparam int DATA_W = 32;  // Avalon data width
  localparam int GA_W = 23;    // Global flash address width
  localparam int WORD_W = 16;  // Command object word width
  localparam int IDX_W = 3;    // Parameter index width
  localparam int NUM_OBJ = 6;  // Command object words held
  localparam int NUM_KEYS = 4; // Backdoor keys

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFF_PARAM_INDEX = 8'h00;
  localparam logic [7:0] OFF_COMMAND_OBJECT = 8'h04;
  localparam logic [7:0] OFF_FLASH_STATUS = 8'h08;
  localparam logic [7:0] OFF_FLASH_CONFIG = 8'h0C;
  localparam logic [7:0] OFF_FLASH_ERROR_CONFIG = 8'h10;
  localparam logic [7:0] OFF_FLASH_ERROR_STATUS = 8'h14;
  localparam logic [7:0] OFF_SECURITY = 8'h18;
  localparam logic [7:0] OFF_DFLASH_PROTECT = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_CCF = 7;    // Command complete flag
  localparam int BIT_ACC = 5;    // Access error flag
  localparam int BIT_PV = 4;     // Protection violation flag
  localparam int BIT_VS_HI = 1;  // Verify status, any error
  localparam int BIT_VS_LO = 0;  // Verify status, uncorrectable
  localparam int BIT_CMD_COMPLETE_IRQ_EN = 7;   // Command complete irq enable
  localparam int BIT_DFD = 1;    // Double fault flag / enable
  localparam int BIT_SFD = 0;    // Single fault flag / enable
  localparam int SEC_LSB = 0;    // Security state bits
  localparam int KEY_ENABLE_FIELD_LSB = 6;  // Key enable field
  localparam int CODE_LSB = 8;   // Command code in word 0
  localparam int GA_HI_W = 7;    // Global address [22:16] in word 0

  ////////////////////////////////////////////////////////////////////////////
  // Codes and reset values
  localparam logic [7:0] CMD_ERASE_DSECTOR = 8'h12;
  localparam logic [7:0] CMD_VERIFY_KEY = 8'h0C;
  localparam logic [IDX_W-1:0] IDX_ERASE = 3'h1;
  localparam logic [IDX_W-1:0] IDX_KEY = 3'h4;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] KEY_ENABLE_FIELD_ENABLED = 2'h2;
  localparam logic [7:0] SEC_RESET_VAL = 8'hFF;
  localparam logic [GA_W-1:0] SEC_BYTE_ADDR = 23'h7FFF0F;
  localparam logic [GA_W-1:0] DF_BASE = 23'h100000;
  localparam logic [GA_W-1:0] DF_SIZE = 23'h001000;
  localparam int DF_SECT_LSB = 8;   // 256 byte sectors
  localparam int DF_SECT_W = 4;     // 16 sectors
  localparam logic [15:0] KEY_ZERO = 16'h0000;
  localparam logic [15:0] KEY_ONES = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_CHECK, ST_ERASE, ST_VERIFY, ST_KEYCHK, ST_DONE
  } fsc_state_t;

  // A key word that may legally serve as a backdoor key
  function automatic logic fsc_key_legal(input logic [15:0] k);
    fsc_key_legal = (k != KEY_ZERO) && (k != KEY_ONES);
  endfunction

endpackage
